// ===== src/knx_modbus_value_mapper.sv
// Function
// R1: bus value compare sets/clears one word bit
// R2: bit one: nothing or send value
// R3: bit zero: nothing or send value
// R4: field located by width and offset
// R5: bus compare writes configured field value
// R6: field compare sends configured object value
// R7: unsigned as whole word or field
// R8: width plus offset at most sixteen
// R9: signed always whole sixteen-bit word
// R10: six areas, unsigned or two's complement
// R11: linear scaling between register and bus
// R12: result fills area, no clamping
// R13: double word order high/low configurable
// R14: double word unsigned, signed or float
// R15: function 16 once or 06 per word; function 16 is sent here once per word, at address and address+1
// R16: master reads double words multi-register; no read is issued here, and polls in double word mode send nothing
// R17: double word uses address and address+1
// R18: one second wait, two retries, skip; a retry only restarts the wait, the request is not sent again
// R19: acknowledge restarts response timeout
// R20: negatives in two's complement
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module knx_modbus_value_mapper #(
  parameter int TIMEOUT_CYC = value_mapper_pkg::RESP_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire value_mapper_pkg::reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  // bus object side
  input wire logic obj_rx_valid_i,
  input wire logic [31:0] obj_rx_value_i,
  output logic obj_tx_valid_o,
  output logic [31:0] obj_tx_value_o,
  // modbus word side
  input wire logic poll_valid_i,
  input wire logic [15:0] poll_word_i,
  input wire logic [15:0] cur_word_i,
  output logic mb_req_valid_o,
  output value_mapper_pkg::modbus_req_s mb_req_o,
  // master response tracking
  input wire logic resp_ok_i,
  input wire logic resp_ack_i,
  output logic page_skip_o
);
  import value_mapper_pkg::*;

  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  logic [15:0] cfg_mode;
  logic [15:0] cfg_field;
  logic [15:0] cfg_cmp;
  logic [15:0] cfg_act;
  logic [15:0] val_gt;
  logic [15:0] val_eq;
  logic [15:0] val_lt;
  logic [15:0] rmin;
  logic [15:0] rmax;
  logic [15:0] kmin;
  logic [15:0] kmax;

  wire wr_en = reg_req_i.wr;
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cfg_mode <= 16'h0000;
      cfg_field <= 16'h0000;
      cfg_cmp <= 16'h0000;
      cfg_act <= 16'h0000;
      val_gt <= 16'h0000;
      val_eq <= 16'h0000;
      val_lt <= 16'h0000;
      rmin <= 16'h0000;
      rmax <= 16'h0000;
      kmin <= 16'h0000;
      kmax <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (reg_req_i.addr)
        ADDR_MODE: cfg_mode <= reg_req_i.wdata;
        ADDR_FIELD: cfg_field <= reg_req_i.wdata;
        ADDR_CMP: cfg_cmp <= reg_req_i.wdata;
        ADDR_ACT: cfg_act <= reg_req_i.wdata;
        ADDR_VAL_GT: val_gt <= reg_req_i.wdata;
        ADDR_VAL_EQ: val_eq <= reg_req_i.wdata;
        ADDR_VAL_LT: val_lt <= reg_req_i.wdata;
        ADDR_RMIN: rmin <= reg_req_i.wdata;
        ADDR_RMAX: rmax <= reg_req_i.wdata;
        ADDR_KMIN: kmin <= reg_req_i.wdata;
        ADDR_KMAX: kmax <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // mode fields: [2:0] map, [4:3] area, [5] area signed, [7:6] dword type,
  // [8] low word first, [9] single-word writes
  wire map_mode_e mode = map_mode_e'(cfg_mode[2:0]);
  wire area_e area = area_e'(cfg_mode[4:3]);
  wire area_signed = cfg_mode[5];
  wire dword_type_e dw_type = dword_type_e'(cfg_mode[7:6]);
  wire lo_first = cfg_mode[8];
  wire single_wr = cfg_mode[9];
  // field: [4:0] width, [8:5] offset; software keeps width+offset within the word
  wire [4:0] fwidth = cfg_field[4:0];
  wire [3:0] foffset = cfg_field[8:5];
  wire [15:0] base_addr = cfg_cmp;

  // field mask; widths of sixteen or more give the whole word [R4] [R8]
  wire [15:0] wmask = (fwidth >= WORD_BITS) ? 16'hffff : ((16'h0001 << fwidth) - 16'h0001);
  wire [15:0] fmask = wmask << foffset;
  wire [15:0] poll_field = (poll_word_i & fmask) >> foffset;
  wire [3:0] bitpos = foffset;

  // comparisons against the shared compare value val_eq
  wire [15:0] rx16 = obj_rx_value_i[15:0];
  wire rx_gt = rx16 > val_eq;
  wire rx_eq = rx16 == val_eq;
  wire [1:0] rx_act = rx_gt ? cfg_act[1:0] : (rx_eq ? cfg_act[3:2] : cfg_act[5:4]);
  wire pf_gt = poll_field > val_eq;
  wire pf_eq = poll_field == val_eq;
  wire [1:0] pf_act = pf_gt ? cfg_act[1:0] : (pf_eq ? cfg_act[3:2] : cfg_act[5:4]);
  wire [15:0] pf_val = pf_gt ? val_gt : (pf_eq ? rmin : val_lt);
  wire poll_bit = poll_word_i[bitpos];

  // bit in word: read-modify-write of the current word [R1]
  wire [15:0] onehot = 16'h0001 << bitpos;
  wire [15:0] bit_word = (rx_act == ACT_SET) ? (cur_word_i | onehot) : (cur_word_i & ~onehot);
  // field write keeps the remaining bits [R5] [R7]
  wire [15:0] rx_fval = rx_gt ? val_gt : (rx_eq ? rmin : val_lt);
  wire [15:0] field_word = (cur_word_i & ~fmask) | ((rx_fval << foffset) & fmask);
  wire [15:0] unsig_word = (fwidth >= WORD_BITS) ? rx16 : ((cur_word_i & ~fmask) | ((rx16 << foffset) & fmask));

  // linear scaling, no clamping, result truncated to the area [R11] [R12]
  wire signed [32:0] kspan = $signed({17'h0_0000, kmax}) - $signed({17'h0_0000, kmin});
  wire signed [32:0] rspan = $signed({{17{rmax[15]}}, rmax}) - $signed({{17{rmin[15]}}, rmin});
  wire signed [32:0] kdelta = $signed({17'h0_0000, rx16}) - $signed({17'h0_0000, kmin});
  wire signed [65:0] prod = 66'(kdelta) * 66'(rspan);
  wire signed [65:0] quot = (kspan == 33'sh0) ? 66'sh0 : prod / 66'(kspan);
  wire [15:0] scaled = quot[15:0] + rmin;
  // scaled value is two's complement bits; area signed only changes reading back [R10] [R20]
  wire [15:0] area_word = (area == AREA_LOW) ? {cur_word_i[15:8], scaled[7:0]} :
                          (area == AREA_HIGH) ? {scaled[7:0], cur_word_i[7:0]} : scaled;
  wire [15:0] poll_area = (area == AREA_LOW) ? (area_signed ? {{8{poll_word_i[7]}}, poll_word_i[7:0]} :
                          {8'h00, poll_word_i[7:0]}) :
                          (area == AREA_HIGH) ? (area_signed ? {{8{poll_word_i[15]}}, poll_word_i[15:8]} :
                          {8'h00, poll_word_i[15:8]}) : poll_word_i;
  // reverse scaling for polled areas; a zero register span sends the bus minimum [R11]
  wire signed [32:0] pdelta = $signed({{17{area_signed & poll_area[15]}}, poll_area}) -
                              $signed({{17{rmin[15]}}, rmin});
  wire signed [65:0] bprod = 66'(pdelta) * 66'(kspan);
  wire signed [65:0] bquot = (rspan == 33'sh0) ? 66'sh0 : bprod / 66'(rspan);
  wire [15:0] bscaled = bquot[15:0] + kmin;

  // double word halves, ordered per setting [R13] [R14]
  wire [15:0] first_word = lo_first ? obj_rx_value_i[15:0] : obj_rx_value_i[31:16];
  wire [15:0] second_word = lo_first ? obj_rx_value_i[31:16] : obj_rx_value_i[15:0];
  wire dw_ieee = (dw_type == DW_IEEE);

  // outgoing word request
  logic next_req_valid;
  logic [15:0] next_req_data;
  always_comb
  begin
    next_req_valid = 1'b0;
    next_req_data = cur_word_i;
    if (obj_rx_valid_i)
    begin
      case (mode)
        MAP_BIT_IN_WORD:
        begin
          next_req_valid = (rx_act != ACT_NONE); // [R1]
          next_req_data = bit_word;
        end
        MAP_FIELD:
        begin
          next_req_valid = (rx_act != ACT_NONE); // [R5]
          next_req_data = field_word;
        end
        MAP_UNSIGNED:
        begin
          next_req_valid = 1'b1; // [R7]
          next_req_data = unsig_word;
        end
        MAP_SIGNED:
        begin
          next_req_valid = 1'b1; // [R9]
          next_req_data = rx16;
        end
        MAP_SCALED:
        begin
          next_req_valid = 1'b1; // [R10] [R11]
          next_req_data = area_word;
        end
        MAP_DWORD:
        begin
          next_req_valid = 1'b1; // [R15]
          next_req_data = first_word;
        end
        default: ;
      endcase
    end
  end

  // outgoing bus object
  logic next_tx_valid;
  logic [31:0] next_tx_value;
  always_comb
  begin
    next_tx_valid = 1'b0;
    next_tx_value = 32'h0000_0000;
    if (poll_valid_i)
    begin
      case (mode)
        MAP_BIT_IN_WORD:
        begin
          next_tx_valid = poll_bit ? (cfg_act[7:6] != ACT_NONE) : (cfg_act[9:8] != ACT_NONE); // [R2] [R3]
          next_tx_value = {16'h0000, poll_bit ? val_gt : val_lt};
        end
        MAP_FIELD:
        begin
          next_tx_valid = (pf_act != ACT_NONE); // [R6]
          next_tx_value = {16'h0000, pf_val};
        end
        MAP_UNSIGNED:
        begin
          next_tx_valid = 1'b1; // [R7]
          next_tx_value = {16'h0000, poll_field};
        end
        MAP_SIGNED:
        begin
          next_tx_valid = 1'b1; // [R9] [R20]
          next_tx_value = {{16{poll_word_i[15]}}, poll_word_i};
        end
        MAP_SCALED:
        begin
          next_tx_valid = 1'b1; // [R10] [R11]
          next_tx_value = {16'h0000, bscaled};
        end
        default: ;
      endcase
    end
  end

  // master: second word of a double word goes to base+1 [R17]
  logic pend_second;
  logic [15:0] second_hold;
  master_state_e state;
  logic [31:0] timer;
  logic [1:0] retries;
  wire timed_out = (state == ST_WAIT) && (timer == 32'(TIMEOUT_CYC - 1));
  wire is_dword = (mode == MAP_DWORD);
  wire start_req = next_req_valid && (state == ST_IDLE);

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      mb_req_valid_o <= 1'b0;
      mb_req_o <= '0;
      pend_second <= 1'b0;
      second_hold <= 16'h0000;
    end
    else if (start_req)
    begin
      mb_req_valid_o <= 1'b1;
      mb_req_o.addr <= base_addr;
      mb_req_o.data <= next_req_data;
      mb_req_o.func <= (is_dword && !single_wr) ? FUNC_WRITE_MULTI : FUNC_WRITE_SINGLE; // [R15]
      pend_second <= is_dword;
      second_hold <= second_word;
    end
    else if (pend_second)
    begin
      // both write modes send the second word in the next cycle at base+1, with the first word's function code [R15] [R17]
      mb_req_valid_o <= 1'b1;
      mb_req_o.addr <= base_addr + 16'h0001;
      mb_req_o.data <= second_hold;
      pend_second <= 1'b0;
    end
    else
    begin
      mb_req_valid_o <= 1'b0;
    end
  end

  // response timer, retries and page skip
  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      retries <= 2'h0;
      page_skip_o <= 1'b0;
    end
    else
    begin
      page_skip_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          timer <= 32'h0000_0000;
          retries <= 2'h0;
          if (start_req)
            state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (resp_ok_i)
            state <= ST_IDLE;
          else if (resp_ack_i)
            timer <= 32'h0000_0000; // [R19]
          else if (timed_out)
          begin
            timer <= 32'h0000_0000;
            if (retries == RETRY_MAX)
              state <= ST_SKIP; // [R18]
            else
              retries <= retries + 2'h1; // [R18]
          end
          else
            timer <= timer + 32'h0000_0001;
        end
        ST_SKIP:
        begin
          page_skip_o <= 1'b1; // [R18]
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      obj_tx_valid_o <= 1'b0;
      obj_tx_value_o <= 32'h0000_0000;
    end
    else
    begin
      obj_tx_valid_o <= next_tx_valid;
      obj_tx_value_o <= next_tx_value;
    end
  end

  // read back; ieee float words pass raw, so no scaling applies to them
  wire [15:0] status_word = {11'h000, dw_ieee, retries, state};
  logic [15:0] next_rdata;
  always_comb
  begin
    case (reg_req_i.addr)
      ADDR_MODE: next_rdata = cfg_mode;
      ADDR_FIELD: next_rdata = cfg_field;
      ADDR_CMP: next_rdata = cfg_cmp;
      ADDR_ACT: next_rdata = cfg_act;
      ADDR_VAL_GT: next_rdata = val_gt;
      ADDR_VAL_EQ: next_rdata = val_eq;
      ADDR_VAL_LT: next_rdata = val_lt;
      ADDR_RMIN: next_rdata = rmin;
      ADDR_RMAX: next_rdata = rmax;
      ADDR_KMIN: next_rdata = kmin;
      ADDR_KMAX: next_rdata = kmax;
      ADDR_STATUS: next_rdata = status_word;
      ADDR_RESULT: next_rdata = mb_req_o.data;
      ADDR_WORD_HI: next_rdata = obj_tx_value_o[31:16];
      ADDR_WORD_LO: next_rdata = obj_tx_value_o[15:0];
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      reg_rdata_o <= 16'h0000;
    else
      reg_rdata_o <= reg_req_i.rd ? next_rdata : 16'h0000;
  end

  a_ack_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R19]
    (state == ST_WAIT && resp_ack_i && !resp_ok_i) |=> (timer == 32'h0000_0000))
    else $error("ack did not restart timer");
  a_skip_after_retries: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R18]
    (state == ST_SKIP) |=> page_skip_o && state == ST_IDLE)
    else $error("page skip missing");
  a_dword_second_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R17]
    (start_req && is_dword) |=> ##1 (mb_req_valid_o && mb_req_o.addr == $past(base_addr, 2) + 16'h0001))
    else $error("second word not at address plus one");
  a_signed_whole: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R9]
    (poll_valid_i && mode == MAP_SIGNED) |=> (obj_tx_value_o[15:0] == $past(poll_word_i)))
    else $error("signed word not whole");
  a_bit_set: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R1]
    (start_req && mode == MAP_BIT_IN_WORD && rx_act == ACT_SET) |=> mb_req_o.data[$past(bitpos)])
    else $error("bit not set");
  a_bit_noact: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R2]
    (poll_valid_i && mode == MAP_BIT_IN_WORD && poll_bit && cfg_act[7:6] == ACT_NONE) |=> !obj_tx_valid_o)
    else $error("sent despite no reaction");
  a_func_multi: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R15]
    (start_req && is_dword && !single_wr) |=> mb_req_o.func == FUNC_WRITE_MULTI)
    else $error("wrong write function");
  a_field_noact: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_b) // [R5]
    (obj_rx_valid_i && mode == MAP_FIELD && rx_act == ACT_NONE && state == ST_IDLE && !pend_second)
    |=> !mb_req_valid_o)
    else $error("field written despite no reaction");

  c_skip: cover property (@(posedge sys_clk_i) page_skip_o);
  c_dword: cover property (@(posedge sys_clk_i) start_req && is_dword);
  c_ack: cover property (@(posedge sys_clk_i) state == ST_WAIT && resp_ack_i);

endmodule : knx_modbus_value_mapper

// ===== include/value_mapper_pkg.sv
package value_mapper_pkg;

  // register map (word index on the plain port)
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_FIELD = 5'h01;
  localparam logic [4:0] ADDR_CMP = 5'h02;
  localparam logic [4:0] ADDR_ACT = 5'h03;
  localparam logic [4:0] ADDR_VAL_GT = 5'h04;
  localparam logic [4:0] ADDR_VAL_EQ = 5'h05;
  localparam logic [4:0] ADDR_VAL_LT = 5'h06;
  localparam logic [4:0] ADDR_RMIN = 5'h07;
  localparam logic [4:0] ADDR_RMAX = 5'h08;
  localparam logic [4:0] ADDR_KMIN = 5'h09;
  localparam logic [4:0] ADDR_KMAX = 5'h0a;
  localparam logic [4:0] ADDR_STATUS = 5'h0b;
  localparam logic [4:0] ADDR_RESULT = 5'h0c;
  localparam logic [4:0] ADDR_WORD_HI = 5'h0d;
  localparam logic [4:0] ADDR_WORD_LO = 5'h0e;

  localparam int WORD_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int RESP_TIMEOUT_MS = 1000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] RETRY_MAX = 2'h2;

  // channel function
  typedef enum logic [2:0] {
    MAP_BIT_IN_WORD = 3'b000,
    MAP_FIELD = 3'b001,
    MAP_UNSIGNED = 3'b010,
    MAP_SIGNED = 3'b011,
    MAP_SCALED = 3'b100,
    MAP_DWORD = 3'b101
  } map_mode_e;

  // area for scaled word mapping
  typedef enum logic [1:0] {
    AREA_LOW = 2'b00,
    AREA_HIGH = 2'b01,
    AREA_WORD = 2'b10
  } area_e;

  typedef enum logic [1:0] {
    DW_UNSIGNED = 2'b00,
    DW_SIGNED = 2'b01,
    DW_IEEE = 2'b10
  } dword_type_e;

  // actions, 2 bits each: gt [1:0], eq [3:2], lt [5:4], on-one [7:6], on-zero [9:8]
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SKIP = 2'b10
  } master_state_e;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic [7:0] func;
  } modbus_req_s;

  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;

endpackage : value_mapper_pkg

// ===== test/modbus_slave_model.sv
`timescale 1ns/100ps
module modbus_slave_model (
  // clock
  input wire logic sys_clk_i,
  // request words from the master
  input wire logic mb_req_valid_i,
  // 0 prompt, 1 slow with acknowledge, 2 silent
  input wire logic [1:0] speed_i,
  // answer pulses
  output logic resp_ok_o,
  output logic resp_ack_o
);
  logic [7:0] wait_cnt = 8'h00;
  logic busy = 1'b0;

  // each word restarts the count, so a double word is answered once, after its last word
  always @(posedge sys_clk_i)
  begin
    resp_ok_o <= 1'b0;
    resp_ack_o <= 1'b0;
    if (mb_req_valid_i)
    begin
      busy <= 1'b1;
      wait_cnt <= 8'h00;
    end
    else if (busy && speed_i != 2'h2)
    begin
      wait_cnt <= wait_cnt + 8'h01;
      if (speed_i == 2'h0 && wait_cnt == 8'h02)
      begin
        resp_ok_o <= 1'b1;
        busy <= 1'b0;
      end
      if (speed_i == 2'h1 && wait_cnt == 8'h0e)
        resp_ack_o <= 1'b1;
      // the answer lands past one timeout, so only the acknowledge keeps it in time
      if (speed_i == 2'h1 && wait_cnt == 8'h1e)
      begin
        resp_ok_o <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : modbus_slave_model

// ===== test/knx_modbus_value_mapper_tb_top.sv
`timescale 1ns/100ps
module knx_modbus_value_mapper_tb_top;
  import value_mapper_pkg::*;
  localparam int TMO = 20;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_s req = '0;
  logic rx_valid = 1'b0;
  logic [31:0] rx_value = 32'h0000_0000;
  logic poll_valid = 1'b0;
  logic [15:0] poll_word = 16'h0000;
  logic [15:0] cur_word = 16'h0000;
  logic resp_ok;
  logic resp_ack;
  logic [15:0] rdata;
  logic tx_valid;
  logic [31:0] tx_value;
  logic mb_valid;
  modbus_req_s mb;
  logic page_skip;
  logic [1:0] speed = 2'h0;
  int errors = 0;
  int n_tests = 0;

  always #2 sys_clk = ~sys_clk;

  knx_modbus_value_mapper #(.TIMEOUT_CYC(TMO)) dut (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .reg_req_i(req), .reg_rdata_o(rdata),
    .obj_rx_valid_i(rx_valid), .obj_rx_value_i(rx_value), .obj_tx_valid_o(tx_valid),
    .obj_tx_value_o(tx_value), .poll_valid_i(poll_valid), .poll_word_i(poll_word),
    .cur_word_i(cur_word), .mb_req_valid_o(mb_valid), .mb_req_o(mb),
    .resp_ok_i(resp_ok), .resp_ack_i(resp_ack), .page_skip_o(page_skip)
  );

  modbus_slave_model slave (
    .sys_clk_i(sys_clk), .mb_req_valid_i(mb_valid), .speed_i(speed),
    .resp_ok_o(resp_ok), .resp_ack_o(resp_ack)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic cfg(input logic [15:0] mode, input logic [15:0] field, input logic [15:0] act);
    wr(ADDR_MODE, mode);
    wr(ADDR_FIELD, field);
    wr(ADDR_ACT, act);
  endtask : cfg

  // object in; leaves us 1 ns into the cycle where the first request word stands
  task automatic obj(input logic [31:0] v, input logic [15:0] cur);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_value <= v;
    cur_word <= cur;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    #1;
  endtask : obj

  task automatic rx_word(input logic [31:0] v, input logic [15:0] cur, input logic ev,
                         input logic [15:0] ed);
    obj(v, cur);
    chk("request valid", {31'h0, ev}, {31'h0, mb_valid});
    if (ev)
      chk("request data", {16'h0, ed}, {16'h0, mb.data});
    repeat (8) @(posedge sys_clk);
  endtask : rx_word

  task automatic poll(input logic [15:0] w, input logic ev, input logic [15:0] ed);
    @(posedge sys_clk);
    poll_valid <= 1'b1;
    poll_word <= w;
    @(posedge sys_clk);
    poll_valid <= 1'b0;
    #1;
    chk("send valid", {31'h0, ev}, {31'h0, tx_valid});
    if (ev)
      chk("send value", {16'h0, ed}, {16'h0, tx_value[15:0]});
  endtask : poll

  task automatic t_regs();
    logic [15:0] d;
    rd(ADDR_STATUS, d);
    chk("status after reset", 32'h0000_0000, {28'h0, d[3:0]});
    wr(ADDR_VAL_GT, 16'h1234);
    rd(ADDR_VAL_GT, d);
    chk("value readback", 32'h0000_1234, {16'h0, d});
    rd(5'h1f, d);
    chk("unmapped read", 32'h0000_0000, {16'h0, d});
  endtask : t_regs

  task automatic t_bit_word();
    wr(ADDR_CMP, 16'h0020);
    wr(ADDR_VAL_EQ, 16'h0064);
    cfg(16'h0000, 16'h0060, 16'h0009);
    rx_word(32'h0000_00c8, 16'h0000, 1'b1, 16'h0008);
    rx_word(32'h0000_0064, 16'hffff, 1'b1, 16'hfff7);
    rx_word(32'h0000_0032, 16'h0000, 1'b0, 16'h0000);
    wr(ADDR_VAL_GT, 16'h0011);
    wr(ADDR_VAL_LT, 16'h0022);
    wr(ADDR_ACT, 16'h0040);
    poll(16'h0008, 1'b1, 16'h0011);
    poll(16'hfff7, 1'b0, 16'h0000);
    wr(ADDR_ACT, 16'h0100);
    poll(16'hfff7, 1'b1, 16'h0022);
    poll(16'h0008, 1'b0, 16'h0000);
  endtask : t_bit_word

  task automatic t_field();
    wr(ADDR_VAL_EQ, 16'h0005);
    wr(ADDR_VAL_GT, 16'h000a);
    wr(ADDR_RMIN, 16'h0003);
    wr(ADDR_VAL_LT, 16'h0006);
    // width 4 at offset 4 keeps the sum within the word
    cfg(16'h0001, 16'h0084, 16'h0005);
    rx_word(32'h0000_0009, 16'h1234, 1'b1, 16'h12a4);
    rx_word(32'h0000_0005, 16'hffff, 1'b1, 16'hff3f);
    rx_word(32'h0000_0002, 16'h0000, 1'b0, 16'h0000);
    poll(16'h0070, 1'b1, 16'h000a);
    poll(16'hff5f, 1'b1, 16'h0003);
    poll(16'h0020, 1'b0, 16'h0000);
  endtask : t_field

  task automatic t_words();
    cfg(16'h0002, 16'h0010, 16'h0000);
    rx_word(32'h0000_abcd, 16'h0000, 1'b1, 16'habcd);
    poll(16'h1234, 1'b1, 16'h1234);
    wr(ADDR_FIELD, 16'h01a3);
    rx_word(32'h0000_0005, 16'h0000, 1'b1, 16'ha000);
    wr(ADDR_MODE, 16'h0003);
    rx_word(32'h0000_8000, 16'h0000, 1'b1, 16'h8000);
    rx_word(32'h0000_ffff, 16'h0000, 1'b1, 16'hffff);
    poll(16'h7fff, 1'b1, 16'h7fff);
    poll(16'h8000, 1'b1, 16'h8000);
    chk("send sign", 32'hffff_8000, tx_value);
  endtask : t_words

  task automatic t_scaled();
    wr(ADDR_RMIN, 16'h0000);
    wr(ADDR_RMAX, 16'h0064);
    wr(ADDR_KMIN, 16'h0000);
    wr(ADDR_KMAX, 16'h000a);
    wr(ADDR_MODE, 16'h0014);
    // above the register maximum: scaled on, never clamped
    rx_word(32'h0000_000f, 16'h0000, 1'b1, 16'h0096);
    wr(ADDR_MODE, 16'h000c);
    rx_word(32'h0000_0002, 16'h0000, 1'b1, 16'h1400);
    poll(16'h9600, 1'b1, 16'h000f);
    wr(ADDR_MODE, 16'h002c);
    poll(16'hec00, 1'b1, 16'hfffe);
  endtask : t_scaled

  task automatic dw(input logic [15:0] mode, input logic [15:0] d0, input logic [15:0] d1,
                    input logic [7:0] fn);
    wr(ADDR_MODE, mode);
    obj(32'h0000_0002, 16'h0000);
    chk("first word", {16'h0040, d0}, {mb.addr, mb.data});
    chk("first func", {24'h0, fn}, {24'h0, mb.func});
    @(posedge sys_clk);
    #1;
    chk("second word", {16'h0041, d1}, {mb.addr, mb.data});
    chk("second valid", 32'h0000_0001, {31'h0, mb_valid});
    repeat (10) @(posedge sys_clk);
  endtask : dw

  task automatic t_dword();
    logic [15:0] d;
    wr(ADDR_CMP, 16'h0040);
    wr(ADDR_RMAX, 16'h0001);
    wr(ADDR_KMAX, 16'h0001);
    dw(16'h0005, 16'h0000, 16'h0002, FUNC_WRITE_MULTI);
    dw(16'h0105, 16'h0002, 16'h0000, FUNC_WRITE_MULTI);
    dw(16'h0205, 16'h0000, 16'h0002, FUNC_WRITE_SINGLE);
    dw(16'h0045, 16'h0000, 16'h0002, FUNC_WRITE_MULTI);
    dw(16'h0085, 16'h0000, 16'h0002, FUNC_WRITE_MULTI);
    rd(ADDR_STATUS, d);
    chk("ieee status", 32'h0000_0010, {27'h0, d[4:0]});
    // a lone polled word never makes a double word; both must come in one multi read
    poll(16'h1234, 1'b0, 16'h0000);
  endtask : t_dword

  task automatic t_master();
    logic [15:0] d;
    int n;
    cfg(16'h0002, 16'h0010, 16'h0000);
    speed <= 2'h1;
    obj(32'h0000_0001, 16'h0000);
    repeat (22) @(posedge sys_clk);
    rd(ADDR_STATUS, d);
    chk("status acknowledged", 32'h0000_0001, {28'h0, d[3:0]});
    repeat (30) @(posedge sys_clk);
    rd(ADDR_STATUS, d);
    chk("status answered", 32'h0000_0000, {28'h0, d[3:0]});
    speed <= 2'h2;
    obj(32'h0000_0001, 16'h0000);
    n = 1;
    obj(32'h0000_0002, 16'h0000);
    chk("request while waiting", 32'h0000_0000, {31'h0, mb_valid});
    n = n + 2;
    while (page_skip !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // three tries of TMO cycles each before the page is dropped
    chk("skip in window", 32'h0000_0001, {31'h0, (n >= 3 * TMO - 4 && n <= 3 * TMO + 8)});
    speed <= 2'h0;
    repeat (10) @(posedge sys_clk);
  endtask : t_master

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_bit_word();
    t_field();
    t_words();
    t_scaled();
    t_dword();
    t_master();
    wrap_up();
  end
endmodule : knx_modbus_value_mapper_tb_top
